// ### bie_params.svh
`ifndef BIE_PARAMS_SVH
`define BIE_PARAMS_SVH

// ----------------------------------------------------------------
// Instruction field layout
// ----------------------------------------------------------------
`define BIE_INSTR_W      12
`define BIE_DATA_W       8
`define BIE_PC_W         11
`define BIE_IMM_W        9
`define BIE_FADDR_W      5
`define BIE_DEST_BIT     5
`define BIE_FADDR_LSB    0

// ----------------------------------------------------------------
// Opcode prefixes
// ----------------------------------------------------------------
`define BIE_JMP_MSB      11
`define BIE_JMP_LSB      9
`define BIE_JMP_CODE     3'h5
`define BIE_INC_MSB      11
`define BIE_INC_LSB      6
`define BIE_INC_CODE     6'h0a
`define BIE_INCSZ_CODE   6'h0f

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define BIE_PC_RST       11'h000
`define BIE_DATA_RST     8'h00
`define BIE_FADDR_RST    5'h00
`define BIE_JMP_CYCLES   2
`define BIE_SKIP_CYCLES  2

`endif

// ### bie_pkg.sv
`include "bie_params.svh"

package bie_pkg;

  // Decoded operation class
  typedef enum logic [1:0] {
    OP_NONE,
    OP_JUMP,
    OP_INC,
    OP_INCSZ
  } bie_op_e;

  // One write-back toward the datapath
  typedef struct packed {
    logic                       we;    // Write pulse
    logic [`BIE_FADDR_W-1:0]    addr;  // File index
    logic [`BIE_DATA_W-1:0]     data;  // Result byte
  } bie_wb_s;

endpackage

// ### bie_incr.sv
`timescale 1ns/100ps
`include "bie_params.svh"

// ----------------------------------------------------------------
// Wrapping incrementer with zero detect
// ----------------------------------------------------------------
module bie_incr #(
  parameter int WIDTH = `BIE_DATA_W
) (
  input  wire logic [WIDTH-1:0] val_i,   // Operand
  output logic      [WIDTH-1:0] sum_o,   // Operand plus one
  output logic                  zero_o   // Sum is zero
);

  // Width below two makes the zero case meaningless; refused at elaboration
  if (WIDTH < 2) begin : g_width_check
    $error("bie_incr: WIDTH must be at least 2");
  end

  // Carry out is dropped on purpose so all-ones wraps to zero
  always_comb begin
    sum_o  = val_i + {{(WIDTH-1){1'b0}}, 1'b1};
    zero_o = (sum_o == '0);
  end

endmodule

// ### bie_exec.sv
`timescale 1ns/100ps
`include "bie_params.svh"

// ----------------------------------------------------------------
// Decode and execute slice: jump, increment, increment-skip
// ----------------------------------------------------------------
module bie_exec #(
  parameter int DATA_W = `BIE_DATA_W
) (
  input  wire logic                      clk_i,          // Instruction clock
  input  wire logic                      rst_n_i,        // Async reset, low
  input  wire logic                      instr_valid_i,  // Word presented
  input  wire logic [`BIE_INSTR_W-1:0]   instr_i,        // Instruction word
  input  wire logic [DATA_W-1:0]         file_rdata_i,   // Addressed file value
  input  wire logic [1:0]                page_i,         // Status page select
  output logic                           pc_load_o,      // Load counter pulse
  output logic [`BIE_PC_W-1:0]           pc_target_o,    // New counter value
  output logic                           discard_o,      // Prefetch dropped
  output logic                           w_we_o,         // Working reg write
  output logic [DATA_W-1:0]              w_data_o,       // Working reg data
  output logic                           f_we_o,         // File reg write
  output logic [`BIE_FADDR_W-1:0]        f_addr_o,       // File reg index
  output logic [DATA_W-1:0]              f_data_o,       // File reg data
  output logic                           z_we_o,         // Zero flag write
  output logic                           z_o             // Zero flag value
);

  // The datapath is byte wide; other widths break the wrap point
  if (DATA_W != `BIE_DATA_W) begin : g_width_check
    $error("bie_exec: DATA_W must be 8");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Shared opcode classifier
  function automatic bie_pkg::bie_op_e op_of(input logic [`BIE_INSTR_W-1:0] w);
    bie_pkg::bie_op_e r;
    r = bie_pkg::OP_NONE;
    if (w[`BIE_JMP_MSB:`BIE_JMP_LSB] == `BIE_JMP_CODE) begin
      r = bie_pkg::OP_JUMP;
    end else if (w[`BIE_INC_MSB:`BIE_INC_LSB] == `BIE_INC_CODE) begin
      r = bie_pkg::OP_INC;
    end else if (w[`BIE_INC_MSB:`BIE_INC_LSB] == `BIE_INCSZ_CODE) begin
      r = bie_pkg::OP_INCSZ;
    end
    return r;
  endfunction

  typedef enum logic {
    ST_RUN,  // Executing presented words
    ST_NOP   // Forced no-op slot
  } bie_state_e;

  bie_state_e               state_r;    // Slot state
  bie_state_e               state_nxt;  // Next slot state
  bie_pkg::bie_op_e         op;         // Current class
  logic [DATA_W-1:0]        inc_sum;    // Incremented value
  logic                     inc_zero;   // Result zero
  logic                     dest;       // Destination select
  logic [`BIE_FADDR_W-1:0]  faddr;      // File index field
  logic                     take;       // Word is executed

  always_comb begin
    op    = op_of(instr_i);
    dest  = instr_i[`BIE_DEST_BIT];
    faddr = instr_i[`BIE_FADDR_LSB +: `BIE_FADDR_W];
    take  = instr_valid_i && (state_r == ST_RUN);
  end

  bie_incr #(
    .WIDTH (DATA_W)
  ) u_incr (
    .val_i  (file_rdata_i),
    .sum_o  (inc_sum),
    .zero_o (inc_zero)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic                     pc_load_nxt;  // Next load pulse
  logic [`BIE_PC_W-1:0]     pc_tgt_nxt;   // Next target
  logic                     discard_nxt;  // Next discard
  bie_pkg::bie_wb_s         wwb_nxt;      // Next working write
  bie_pkg::bie_wb_s         fwb_nxt;      // Next file write
  logic                     z_we_nxt;     // Next flag write
  logic                     z_nxt;        // Next flag value

  // Pulses default low; data holds so a scope sees last result
  always_comb begin
    state_nxt   = ST_RUN;
    pc_load_nxt = 1'b0;
    pc_tgt_nxt  = pc_target_o;
    discard_nxt = 1'b0;
    wwb_nxt     = '{we: 1'b0, addr: `BIE_FADDR_RST, data: w_data_o};
    fwb_nxt     = '{we: 1'b0, addr: f_addr_o, data: f_data_o};
    z_we_nxt    = 1'b0;
    z_nxt       = z_o;
    if (take) begin
      unique case (op)
        bie_pkg::OP_JUMP: begin
          // Page bits on top, immediate below; flags untouched
          pc_load_nxt = 1'b1;
          pc_tgt_nxt  = {page_i, instr_i[`BIE_IMM_W-1:0]};
          discard_nxt = 1'b1;
          state_nxt   = ST_NOP;
        end
        bie_pkg::OP_INC, bie_pkg::OP_INCSZ: begin
          // Result goes to working reg on 0, file reg on 1
          if (dest) begin
            fwb_nxt = '{we: 1'b1, addr: faddr, data: inc_sum};
          end else begin
            wwb_nxt = '{we: 1'b1, addr: faddr, data: inc_sum};
          end
          if (op == bie_pkg::OP_INC) begin
            z_we_nxt = 1'b1;
            z_nxt    = inc_zero;
          end else if (inc_zero) begin
            // Skip form never writes the flag
            discard_nxt = 1'b1;
            state_nxt   = ST_NOP;
          end
        end
        bie_pkg::OP_NONE: begin
          // Other instructions belong to other slices
        end
      endcase
    end
    // In ST_NOP the presented word is the discarded prefetch
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Only registers next values; every output is a flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= ST_RUN;
      pc_load_o   <= 1'b0;
      pc_target_o <= `BIE_PC_RST;
      discard_o   <= 1'b0;
      w_we_o      <= 1'b0;
      w_data_o    <= `BIE_DATA_RST;
      f_we_o      <= 1'b0;
      f_addr_o    <= `BIE_FADDR_RST;
      f_data_o    <= `BIE_DATA_RST;
      z_we_o      <= 1'b0;
      z_o         <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      pc_load_o   <= pc_load_nxt;
      pc_target_o <= pc_tgt_nxt;
      discard_o   <= discard_nxt;
      w_we_o      <= wwb_nxt.we;
      w_data_o    <= wwb_nxt.data;
      f_we_o      <= fwb_nxt.we;
      f_addr_o    <= fwb_nxt.addr;
      f_data_o    <= fwb_nxt.data;
      z_we_o      <= z_we_nxt;
      z_o         <= z_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_jump_in;
    take && (op == bie_pkg::OP_JUMP);
  endsequence

  sequence s_skip_in;
    take && (op == bie_pkg::OP_INCSZ) && (file_rdata_i == 8'hff);
  endsequence

  property p_jump_target;
    s_jump_in |=> pc_load_o && discard_o && !z_we_o
                  && (pc_target_o == {$past(page_i), $past(instr_i[8:0])});
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

  property p_jump_two;
    s_jump_in |=> (state_r == ST_NOP) ##1 (state_r == ST_RUN);
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

  property p_inc_zero;
    take && (op == bie_pkg::OP_INC) |=> z_we_o && !discard_o
                                        && (z_o == ($past(file_rdata_i) == 8'hff));
  endproperty
  a_inc_zero: assert property (p_inc_zero) else $error("increment flag wrong");

  property p_dest_w;
    take && (op != bie_pkg::OP_NONE) && (op != bie_pkg::OP_JUMP) && !dest
      |=> w_we_o && !f_we_o && (w_data_o == 8'($past(file_rdata_i) + 8'h01));
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("working write wrong");

  property p_dest_f;
    take && (op != bie_pkg::OP_NONE) && (op != bie_pkg::OP_JUMP) && dest
      |=> f_we_o && !w_we_o && (f_addr_o == $past(faddr))
          && (f_data_o == 8'($past(file_rdata_i) + 8'h01));
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("file write wrong");

  property p_skip_flag;
    take && (op == bie_pkg::OP_INCSZ) |=> !z_we_o && (discard_o == ($past(file_rdata_i) == 8'hff));
  endproperty
  a_skip_flag: assert property (p_skip_flag) else $error("skip request wrong");

  property p_skip_nop;
    s_skip_in |=> (state_r == ST_NOP) && !pc_load_o ##1 !w_we_o && !f_we_o && !z_we_o && !discard_o;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("discarded word ran");

  property p_wrap;
    take && (op == bie_pkg::OP_INC) && (file_rdata_i == 8'hff) && dest |=> f_data_o == 8'h00 && z_o;
  endproperty
  a_wrap: assert property (p_wrap) else $error("increment did not wrap");

endmodule

// ### bie_core_model.sv
`timescale 1ns/100ps
`include "bie_params.svh"

// ----------------------------------------------------------------
// Core datapath model: file register array
// ----------------------------------------------------------------
module bie_core_model (
  input  wire logic                     clk_i,      // Instruction clock
  input  wire logic [`BIE_INSTR_W-1:0]  instr_i,    // Word on the bus
  input  wire logic                     ld_i,       // Bench preload strobe
  input  wire logic [`BIE_FADDR_W-1:0]  ld_addr_i,  // Preload index
  input  wire logic [`BIE_DATA_W-1:0]   ld_data_i,  // Preload value
  input  wire logic                     f_we_i,     // Write-back pulse
  input  wire logic [`BIE_FADDR_W-1:0]  f_addr_i,   // Write-back index
  input  wire logic [`BIE_DATA_W-1:0]   f_data_i,   // Write-back value
  output logic      [`BIE_DATA_W-1:0]   rdata_o     // Addressed file value
);
  logic [`BIE_DATA_W-1:0] file_r [32];  // File registers

  // Read is combinational, same cycle as the word
  assign rdata_o = file_r[instr_i[`BIE_FADDR_W-1:0]];

  // Write-back wins over a preload to the same index
  always_ff @(posedge clk_i) begin
    if (ld_i) begin
      file_r[ld_addr_i] <= ld_data_i;
    end
    if (f_we_i) begin
      file_r[f_addr_i] <= f_data_i;
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
`include "bie_params.svh"

module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                     clk_i = 1'b0;          // 250 MHz clock
  logic                     rst_n_i = 1'b0;        // Reset, low
  logic                     instr_valid_i = 1'b0;  // Word valid
  logic [`BIE_INSTR_W-1:0]  instr_i = 12'h000;     // Word
  logic [1:0]               page_i = 2'h0;         // Page select
  logic                     ld = 1'b0;             // Preload strobe
  logic [`BIE_FADDR_W-1:0]  ld_addr = 5'h00;       // Preload index
  logic [`BIE_DATA_W-1:0]   ld_data = 8'h00;       // Preload value
  logic [`BIE_DATA_W-1:0]   rdata;                 // File read value
  logic [`BIE_PC_W-1:0]     pc_target;             // Jump target
  logic [`BIE_DATA_W-1:0]   w_data, f_data;        // Result bytes
  logic [`BIE_FADDR_W-1:0]  f_addr;                // Result index
  logic                     pc_load, discard, w_we, f_we, z_we, z;  // Pulses and flag
  int                       num_errors = 0;        // Mismatches
  int                       comparisons = 0;       // Compares made

  // 4 ns period
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  bie_exec i_bie_exec (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .file_rdata_i(rdata), .page_i(page_i), .pc_load_o(pc_load),
    .pc_target_o(pc_target), .discard_o(discard), .w_we_o(w_we), .w_data_o(w_data),
    .f_we_o(f_we), .f_addr_o(f_addr), .f_data_o(f_data), .z_we_o(z_we), .z_o(z));

  bie_core_model i_bie_core_model (.clk_i(clk_i), .instr_i(instr_i), .ld_i(ld),
    .ld_addr_i(ld_addr), .ld_data_i(ld_data), .f_we_i(f_we), .f_addr_i(f_addr),
    .f_data_i(f_data), .rdata_o(rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Drive one slot at a rising edge
  task automatic send(input logic v, input logic [11:0] w);
    @(posedge clk_i);
    instr_valid_i <= v;
    instr_i       <= w;
  endtask

  // Pulse set {pc_load, discard, w_we, f_we, z_we}, once settled
  task automatic pulses(input logic [4:0] exp);
    #1;
    check("pulses", {11'h000, pc_load, discard, w_we, f_we, z_we}, {11'h000, exp});
  endtask

  // Preload lands at the second edge, before the next word
  task automatic preload(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    ld            <= 1'b1;
    ld_addr       <= a;
    ld_data       <= v;
    @(posedge clk_i);
    ld            <= 1'b0;
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Jump on every page, word in the eaten slot must be dropped
  task automatic test_jump();
    logic [8:0] k;
    for (int p = 0; p < 4; p++) begin
      k = (p == 0) ? 9'h000 : (p == 1) ? 9'h1ff : 9'h0a5;
      send(1'b1, {3'h5, k});
      page_i <= 2'(p);
      send(1'b1, 12'h2a1);
      pulses(5'h18);
      check("pc_target", 16'(pc_target), 16'({2'(p), k}));
      send(1'b0, 12'h000);
      pulses(5'h00);
    end
    $display("test_jump done");
  endtask

  // Both increment forms, both destinations, wrap at 0xff
  task automatic test_increment();
    logic [7:0] v, r;
    logic [4:0] a;
    logic       d, sk, zr;
    for (int i = 0; i < 12; i++) begin
      sk = i[0];
      d  = i[1];
      v  = (i < 4) ? 8'hff : (i < 8) ? 8'hfe : 8'h7f;
      a  = d ? 5'h1f : 5'(i);
      r  = v + 8'h01;
      zr = (r == 8'h00);
      preload(a, v);
      send(1'b1, {sk ? 6'h0f : 6'h0a, d, a});
      send(sk & zr, 12'h2a1);
      pulses({1'b0, sk & zr, ~d, d, ~sk});
      if (d) check("f_addr", 16'(f_addr), 16'(a));
      if (d) check("f_data", 16'(f_data), 16'(r));
      if (!d) check("w_data", 16'(w_data), 16'(r));
      if (!sk) check("z", 16'(z), 16'(zr));
      send(1'b0, 12'h000);
      pulses(5'h00);
      check("stored", 16'(i_bie_core_model.file_r[a]), 16'(d ? r : v));
    end
    $display("test_increment done");
  endtask

  // Mid-run reset clears held results; word right after release is taken
  task automatic test_reset();
    send(1'b1, 12'hbff);
    send(1'b0, 12'h000);
    pulses(5'h18);
    check("pc_target", 16'(pc_target), 16'h07ff);
    preload(5'h1f, 8'hff);
    // Outputs still hold earlier results here, so zeros prove the reset
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    #1;
    check("reset target", {5'h00, pc_target}, 16'h0000);
    check("reset data", {w_data, f_data}, 16'h0000);
    check("reset ctrl", {5'h00, f_addr, z, pc_load, discard, w_we, f_we, z_we}, 16'h0000);
    // Release and first word in the same cycle
    @(posedge clk_i);
    rst_n_i       <= 1'b1;
    instr_valid_i <= 1'b1;
    instr_i       <= 12'h29f;
    send(1'b0, 12'h000);
    pulses(5'h05);
    check("w_data", 16'(w_data), 16'h0000);
    check("z", 16'(z), 16'h0001);
    $display("test_reset done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    pulses(5'h00);
    test_jump();
    test_increment();
    test_reset();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("run did not finish in time");
    results();
  end
endmodule
